// >>> ifvu_chk.sv
// Assertion checker for the interrupt flag and vector unit ports
`timescale 1ns/1ps
`default_nettype none
module ifvu_chk (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic core_irq,
	input wire logic vector_load,
	input wire logic push_return,
	input wire logic [12:0] vector_addr,
	input wire logic [3:0] quarter_phase,
	input wire logic core_sleeping,
	input wire logic core_wake,
	input wire logic core_gie_clear
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!resetn);
	// A flush restarts the sampling, so only an undisturbed run counts
	sequence s_irq_held;
		(core_irq && !core_gie_clear) [*8];
	endsequence
	sequence s_entry;
		vector_load && push_return;
	endsequence
	chk_push_pair: assert property (vector_load == push_return)
		else $error("push and load apart");
	chk_vec_addr: assert property (s_entry |=> vector_addr == 13'h0004 && !vector_load)
		else $error("vector address wrong");
	chk_gie_drop: assert property (s_entry |-> !core_irq && $past(core_irq))
		else $error("request not cut at entry");
	chk_q1_service: assert property (vector_load |-> quarter_phase == 4'b0010)
		else $error("entry off the quarter grid");
	chk_irq_latency: assert property (s_irq_held |-> ##[1:10] vector_load)
		else $error("request not serviced in time");
	chk_gie_flush: assert property (core_gie_clear |-> ##2 !vector_load [*6])
		else $error("entry right after global clear");
	chk_wake_sleep: assert property (!core_sleeping |=> !core_wake)
		else $error("wake while awake");
	chk_phase_walk: assert property (quarter_phase == 4'b1000 |=> quarter_phase == 4'b0001)
		else $error("phase order broken");
endmodule
bind ifvu_top ifvu_chk u_chk (.*);
`default_nettype wire

// >>> ifvu_core_mdl.sv
// Core-side model: sleep state and handler entry count
`timescale 1ns/1ps
`default_nettype none
module ifvu_core_mdl (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic sleep_req,
	input wire logic core_wake,
	input wire logic vector_load,
	input wire logic push_return,
	output logic core_sleeping,
	output int n_entry
);
	// Wake ends sleep at once; the prefetched instruction is not modelled
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			core_sleeping <= 1'b0;
			n_entry <= 0;
		end else begin
			if (core_wake)
				core_sleeping <= 1'b0;
			else if (sleep_req)
				core_sleeping <= 1'b1;
			if (vector_load && push_return)
				n_entry <= n_entry + 1;
		end
	end
endmodule
`default_nettype wire

// >>> ifvu_defines.vh
// Constants of the interrupt flag and vector unit
// Contract
// [RL1] Global enable passes unmasked requests when set, blocks all when clear; reset clears it.
// [RL2] Return-from-handler leaves the handler and sets global enable again.
// [RL3] Servicing clears global enable, pushes return address, loads vector 0004h.
// [RL4] Each flag sets on its event regardless of any enable bit.
// [RL5] Clearing global enable drops next-cycle requests, which stay pending for later.
// [RL6] Event to vector takes 3-4 cycles asynchronous, exactly 3 synchronous.
// [RL7] External pin is edge triggered; polarity chosen by option bit 6.
// [RL8] A valid external edge sets control bit 1; control bit 4 enables it.
// [RL9] External edge wakes sleep if enabled; global enable decides vectoring afterwards.
// [RL10] Timer rollover FFh to 00h sets control bit 2; control bit 5 enables.
// [RL11] Change on an enabled port pin sets control bit 0; bit 3 enables.
// [RL12] A pin change at the start of quarter two may leave the flag clear.
// [RL13] Conversion done sets peripheral flag bit 6; peripheral enable bit 6 gates.
// [RL14] Peripheral flags: write-complete 7, converter 6, comparator 3, second timer 0.
// [RL15] External flag sampled every quarter one; may set during quarters four to one.
// [RL16] Only the return address is saved on entry; no other registers.
// [RL17] Handler software clears serviced flags before re-enabling, else the request repeats.
// [RL18] Any enabled set flag wakes sleep whatever global enable says.
// [RL19] Peripheral request needs flag, own enable, group enable and global enable.
// [RL20] Core-group request needs flag, own enable and global enable.
`ifndef IFVU_DEFINES_VH
`define IFVU_DEFINES_VH

`define IFVU_AW 12
`define IFVU_DW 32
// Register indices; byte address is four times the index
`define IFVU_IDX_CTRL 12'h000B
`define IFVU_IDX_PFLAG 12'h000C
`define IFVU_IDX_PEN 12'h008C
`define IFVU_IDX_OPTION 12'h0081
`define IFVU_IDX_PINEN 12'h0096

// Control register bits
`define IFVU_B_GIE 7
`define IFVU_B_PGE 6
`define IFVU_B_TOE 5
`define IFVU_B_EXE 4
`define IFVU_B_PCE 3
`define IFVU_B_TOF 2
`define IFVU_B_EXF 1
`define IFVU_B_PCF 0
// Peripheral flag and enable bits
`define IFVU_B_WRC 7
`define IFVU_B_CNV 6
`define IFVU_B_CMP 3
`define IFVU_B_TM2 0
`define IFVU_PERI_MASK 8'hC9
// Option register bits
`define IFVU_B_EDGE 6
`define IFVU_OPTION_RST 8'hFF
`define IFVU_PINEN_MASK 8'h3F

`define IFVU_RST8 8'h00
`define IFVU_VECTOR 13'h0004
`define IFVU_NPINS 6
`define IFVU_RESP_OKAY 2'b00
`define IFVU_RESP_SLVERR 2'b10

// Quarter phase one-hot codes
`define IFVU_Q1 4'b0001
`define IFVU_Q2 4'b0010
`define IFVU_Q3 4'b0100
`define IFVU_Q4 4'b1000

`endif

// >>> ifvu_pin_events.v
// Edge and change detection for the external request pin and the port pins
`timescale 1ns/1ps
`default_nettype none
`include "ifvu_defines.vh"
module ifvu_pin_events (
	input wire mclk,
	input wire resetn,
	input wire ext_pin,
	input wire edge_rising_sel,
	input wire [`IFVU_NPINS-1:0] port_pins,
	input wire [`IFVU_NPINS-1:0] per_pin_change_enables,
	input wire q2_start,
	output wire ext_edge,
	output wire port_change
);
	reg ext_q;
	reg [`IFVU_NPINS-1:0] pins_q;
	wire [`IFVU_NPINS-1:0] pin_hit;

	always @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			ext_q <= 1'b0;
			pins_q <= {`IFVU_NPINS{1'b0}};
		end else begin
			ext_q <= ext_pin;
			pins_q <= port_pins;
		end
	end

	// Edge direction follows the option bit  see [RL7]
	assign ext_edge = edge_rising_sel ? (ext_pin & ~ext_q) : (~ext_pin & ext_q);

	genvar i;
	generate
		for (i = 0; i < `IFVU_NPINS; i = i + 1) begin : g_pin
			assign pin_hit[i] = per_pin_change_enables[i] & (port_pins[i] ^ pins_q[i]); // see [RL11]
		end
	endgenerate

	// A change landing on the port read slot is dropped, as the port latch would miss it  see [RL12]
	assign port_change = (|pin_hit) & ~q2_start;
endmodule
`default_nettype wire

// >>> ifvu_tb.sv
// Self-checking bench for the interrupt flag and vector unit
`timescale 1ns/1ps
`default_nettype none
`include "ifvu_defines.vh"
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin n_mismatch++; \
	$display("BAD t=%0t got %h exp %h", $time, a, e); end end
module testbench;
	localparam logic [11:0] A_CTRL = `IFVU_IDX_CTRL << 2;
	localparam logic [11:0] A_PF = `IFVU_IDX_PFLAG << 2;
	localparam logic [11:0] A_PE = `IFVU_IDX_PEN << 2;
	localparam logic [11:0] A_OPT = `IFVU_IDX_OPTION << 2;
	localparam logic [11:0] A_PIN = `IFVU_IDX_PINEN << 2;
	logic mclk = 0, resetn = 0, ext_pin = 0, sleep_req = 0;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
	logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, core_irq, core_wake, vector_load, push_return, core_sleeping;
	logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
	logic [31:0] s_axi_wdata = '0, s_axi_rdata;
	logic [2:0] s_axi_awprot = '0, s_axi_arprot = '0;
	logic [3:0] s_axi_wstrb = 4'hF, quarter_phase;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [5:0] port_pins = '0;
	logic [6:0] ev = '0;
	logic [12:0] vector_addr;
	int n_mismatch = 0, compares = 0, cyc = 0, n, n_entry;
	always #20 mclk = ~mclk;
	ifvu_top u_dut (.*, .timer_rollover(ev[0]), .comparator_change(ev[1]),
		.converter_done(ev[2]), .second_timer_overflow(ev[3]), .write_complete(ev[4]),
		.core_gie_clear(ev[5]), .return_from_handler(ev[6]));
	ifvu_core_mdl u_core (.*);
	// Handshakes are judged on settled values at the falling edge before each rising edge
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		logic aw_hs, w_hs, b_hs;
		logic [1:0] resp;
		@(posedge mclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h00_0000, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(negedge mclk);
			aw_hs = s_axi_awvalid & s_axi_awready;
			w_hs = s_axi_wvalid & s_axi_wready;
			b_hs = s_axi_bvalid;
			resp = s_axi_bresp;
			@(posedge mclk);
			if (aw_hs) s_axi_awvalid <= 1'b0;
			if (w_hs) s_axi_wvalid <= 1'b0;
		end while (b_hs !== 1'b1);
		s_axi_bready <= 1'b0;
		`CHK(resp, `IFVU_RESP_OKAY)
	endtask
	task automatic rd(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er = 2'h0);
		logic ar_hs, r_hs;
		logic [31:0] data;
		logic [1:0] resp;
		@(posedge mclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(negedge mclk);
			ar_hs = s_axi_arvalid & s_axi_arready;
			r_hs = s_axi_rvalid;
			data = s_axi_rdata;
			resp = s_axi_rresp;
			@(posedge mclk);
			if (ar_hs) s_axi_arvalid <= 1'b0;
		end while (r_hs !== 1'b1);
		s_axi_rready <= 1'b0;
		`CHK(data, {24'h00_0000, d})
		`CHK(resp, er)
	endtask
	task automatic pulse(input logic [6:0] m);
		@(posedge mclk);
		ev <= m;
		@(posedge mclk);
		ev <= '0;
	endtask
	task automatic wait_vec();
		n = 1;
		@(negedge mclk);
		while (vector_load !== 1'b1 && n < 40) begin
			@(negedge mclk);
			n++;
		end
		`CHK(push_return, 1'b1)
		`CHK(vector_addr, `IFVU_VECTOR)
		@(negedge mclk);
		`CHK(vector_load, 1'b0)
		@(posedge mclk);
	endtask
	task automatic stop_test();
		$display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// The whole sequence needs well under a thousand cycles
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 4000) begin
			n_mismatch++;
			stop_test();
		end
	end
	initial begin
		repeat (3) @(posedge mclk);
		resetn <= 1'b1;
		rd(A_CTRL, 8'h00);
		rd(A_PF, 8'h00);
		rd(A_PE, 8'h00);
		rd(A_OPT, 8'hFF);
		rd(A_PIN, 8'h00);
		rd(12'h010, 8'h00, `IFVU_RESP_SLVERR);
		pulse(7'h1F);
		rd(A_CTRL, 8'h04);
		rd(A_PF, 8'hC9);
		`CHK(core_irq, 1'b0)
		wr(A_PE, 8'hFF);
		rd(A_PE, 8'hC9);
		$display("flags and reset test done");
		wr(A_CTRL, 8'h80);
		`CHK(core_irq, 1'b0)
		wr(A_CTRL, 8'hC0);
		@(posedge mclk);
		`CHK(core_irq, 1'b1)
		wait_vec();
		rd(A_CTRL, 8'h40);
		wr(A_PF, 8'h00);
		pulse(7'h40);
		rd(A_CTRL, 8'hC0);
		`CHK(core_irq, 1'b0)
		$display("peripheral entry test done");
		wr(A_CTRL, 8'hA0);
		pulse(7'h21);
		pulse(7'h40);
		wait_vec();
		rd(A_CTRL, 8'h24);
		$display("flushed request test done");
		wr(A_CTRL, 8'h00);
		wr(A_OPT, 8'h40);
		wr(A_CTRL, 8'h90);
		@(posedge mclk);
		ext_pin <= 1'b1;
		wait_vec();
		`CHK(n inside {[8:17]}, 1'b1)
		rd(A_CTRL, 8'h12);
		wr(A_CTRL, 8'h10);
		ext_pin <= 1'b0;
		repeat (8) @(posedge mclk);
		rd(A_CTRL, 8'h10);
		wr(A_OPT, 8'h00);
		wr(A_CTRL, 8'h10);
		ext_pin <= 1'b1;
		repeat (8) @(posedge mclk);
		rd(A_CTRL, 8'h10);
		ext_pin <= 1'b0;
		repeat (8) @(posedge mclk);
		rd(A_CTRL, 8'h12);
		$display("external edge test done");
		wr(A_CTRL, 8'h08);
		wr(A_PIN, 8'h01);
		sleep_req <= 1'b1;
		@(posedge mclk);
		sleep_req <= 1'b0;
		port_pins <= 6'h02;
		repeat (8) @(posedge mclk);
		`CHK(core_sleeping, 1'b1)
		// Change in quarter one, clear of the port read at quarter two
		@(negedge mclk);
		while (quarter_phase !== `IFVU_Q4) @(negedge mclk);
		@(posedge mclk);
		port_pins <= 6'h03;
		repeat (12) @(posedge mclk);
		`CHK(core_sleeping, 1'b0)
		`CHK(n_entry, 3)
		rd(A_CTRL, 8'h09);
		// A change landing in quarter two is dropped
		wr(A_CTRL, 8'h08);
		@(negedge mclk);
		while (quarter_phase !== `IFVU_Q1) @(negedge mclk);
		@(posedge mclk);
		port_pins <= 6'h02;
		repeat (4) @(posedge mclk);
		rd(A_CTRL, 8'h08);
		$display("port change wake test done");
		stop_test();
	end
endmodule
`default_nettype wire

// >>> ifvu_top.v
// Interrupt flag, mask, vector and wake logic with an AXI4-Lite register slave
`timescale 1ns/1ps
`default_nettype none
`include "ifvu_defines.vh"
module ifvu_top (
	input wire mclk,
	input wire resetn,
	input wire [`IFVU_AW-1:0] s_axi_awaddr,
	input wire [2:0] s_axi_awprot,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [`IFVU_DW-1:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [`IFVU_AW-1:0] s_axi_araddr,
	input wire [2:0] s_axi_arprot,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output reg [`IFVU_DW-1:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	input wire ext_pin,
	input wire [`IFVU_NPINS-1:0] port_pins,
	input wire timer_rollover,
	input wire comparator_change,
	input wire converter_done,
	input wire second_timer_overflow,
	input wire write_complete,
	input wire core_sleeping,
	input wire core_gie_clear,
	input wire return_from_handler,
	output wire core_irq,
	output reg core_wake,
	output reg vector_load,
	output reg push_return,
	output reg [12:0] vector_addr,
	output wire [3:0] quarter_phase
);
	reg [7:0] ctrl_q;
	reg [7:0] pflag_q;
	reg [7:0] pen_q;
	reg [7:0] option_q;
	reg [7:0] pinen_q;
	reg [3:0] phase_q;
	reg [`IFVU_AW-1:0] awaddr_q;
	reg aw_full_q;
	reg [7:0] wdata_q;
	reg w_full_q;
	reg samp1_q;
	reg samp2_q;
	reg ext_pend_q;
	reg [7:0] ctrl_d;
	reg [7:0] pflag_d;
	reg [3:0] phase_d;
	wire ext_edge;
	wire port_change;
	wire wr_go;
	wire core_req;
	wire peri_req;
	wire any_req;
	wire service;
	wire wake_d;

	// Register index hit; the low two address bits are ignored
	function hit;
		input [`IFVU_AW-1:0] addr;
		input [`IFVU_AW-1:0] idx;
		begin
			hit = (addr[`IFVU_AW-1:2] == idx[`IFVU_AW-3:0]);
		end
	endfunction

	function mapped;
		input [`IFVU_AW-1:0] addr;
		begin
			mapped = hit(addr, `IFVU_IDX_CTRL) | hit(addr, `IFVU_IDX_PFLAG) |
				hit(addr, `IFVU_IDX_PEN) | hit(addr, `IFVU_IDX_OPTION) |
				hit(addr, `IFVU_IDX_PINEN);
		end
	endfunction

	ifvu_pin_events u_pins (
		.mclk(mclk),
		.resetn(resetn),
		.ext_pin(ext_pin),
		.edge_rising_sel(option_q[`IFVU_B_EDGE]),
		.port_pins(port_pins),
		.per_pin_change_enables(pinen_q[`IFVU_NPINS-1:0]),
		.q2_start(phase_q[1]),
		.ext_edge(ext_edge),
		.port_change(port_change)
	);

	// Quarter phases of the instruction cycle, one mclk each
	always @* begin
		case (phase_q)
			`IFVU_Q1: phase_d = `IFVU_Q2;
			`IFVU_Q2: phase_d = `IFVU_Q3;
			`IFVU_Q3: phase_d = `IFVU_Q4;
			`IFVU_Q4: phase_d = `IFVU_Q1;
			default: phase_d = `IFVU_Q1;
		endcase
	end
	assign quarter_phase = phase_q;

	// Write channel: address and data taken in either order, one at a time
	assign s_axi_awready = ~aw_full_q & ~s_axi_bvalid;
	assign s_axi_wready = ~w_full_q & ~s_axi_bvalid;
	assign wr_go = aw_full_q & w_full_q & ~s_axi_bvalid;
	assign s_axi_arready = ~s_axi_rvalid;

	// Request qualification  see [RL19] see [RL20]
	assign core_req = (ctrl_q[`IFVU_B_TOF] & ctrl_q[`IFVU_B_TOE]) |
		(ctrl_q[`IFVU_B_EXF] & ctrl_q[`IFVU_B_EXE]) |
		(ctrl_q[`IFVU_B_PCF] & ctrl_q[`IFVU_B_PCE]);
	assign peri_req = ctrl_q[`IFVU_B_PGE] & (|(pflag_q & pen_q & `IFVU_PERI_MASK));
	assign any_req = core_req | peri_req;
	assign core_irq = ctrl_q[`IFVU_B_GIE] & any_req; // see [RL1]
	// Wake ignores global enable  see [RL9] see [RL18]
	assign wake_d = core_sleeping & any_req;
	// Two quarter-one samples then take: 3 cycles from a synchronous event  see [RL6]
	assign service = phase_q[0] & samp2_q & core_irq & ~core_gie_clear;

	always @* begin
		ctrl_d = ctrl_q;
		pflag_d = pflag_q;
		// Decode the held address here: bresp still shows the previous write
		if (wr_go && mapped(awaddr_q)) begin
			if (hit(awaddr_q, `IFVU_IDX_CTRL))
				ctrl_d = wdata_q;
			if (hit(awaddr_q, `IFVU_IDX_PFLAG))
				pflag_d = wdata_q & `IFVU_PERI_MASK; // see [RL14]
		end
		if (return_from_handler)
			ctrl_d[`IFVU_B_GIE] = 1'b1; // see [RL2]
		if (core_gie_clear || service)
			ctrl_d[`IFVU_B_GIE] = 1'b0; // see [RL3]
		// Events are set after any clear so a same-cycle event survives  see [RL4]
		if (timer_rollover)
			ctrl_d[`IFVU_B_TOF] = 1'b1; // see [RL10]
		if (ext_pend_q && (phase_q[3] || phase_q[0]))
			ctrl_d[`IFVU_B_EXF] = 1'b1; // see [RL8] see [RL15]
		if (ext_edge && (phase_q[3] || phase_q[0]))
			ctrl_d[`IFVU_B_EXF] = 1'b1;
		if (port_change)
			ctrl_d[`IFVU_B_PCF] = 1'b1; // see [RL11]
		if (write_complete)
			pflag_d[`IFVU_B_WRC] = 1'b1; // see [RL14]
		if (converter_done)
			pflag_d[`IFVU_B_CNV] = 1'b1; // see [RL13]
		if (comparator_change)
			pflag_d[`IFVU_B_CMP] = 1'b1;
		if (second_timer_overflow)
			pflag_d[`IFVU_B_TM2] = 1'b1;
	end

	always @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			ctrl_q <= `IFVU_RST8; // see [RL1]
			pflag_q <= `IFVU_RST8;
			pen_q <= `IFVU_RST8;
			option_q <= `IFVU_OPTION_RST;
			pinen_q <= `IFVU_RST8;
			phase_q <= `IFVU_Q1;
			awaddr_q <= {`IFVU_AW{1'b0}};
			aw_full_q <= 1'b0;
			wdata_q <= `IFVU_RST8;
			w_full_q <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `IFVU_RESP_OKAY;
			s_axi_rvalid <= 1'b0;
			s_axi_rresp <= `IFVU_RESP_OKAY;
			s_axi_rdata <= {`IFVU_DW{1'b0}};
			samp1_q <= 1'b0;
			samp2_q <= 1'b0;
			ext_pend_q <= 1'b0;
			core_wake <= 1'b0;
			vector_load <= 1'b0;
			push_return <= 1'b0;
			vector_addr <= {13{1'b0}};
		end else begin
			phase_q <= phase_d;
			ctrl_q <= ctrl_d;
			pflag_q <= pflag_d;
			core_wake <= wake_d;
			// Edges seen in quarters two and three wait for the set window  see [RL15]
			if (phase_q[3] || phase_q[0])
				ext_pend_q <= 1'b0;
			else if (ext_edge)
				ext_pend_q <= 1'b1;
			// Flush on global-enable clear; flags stay set and retrigger later  see [RL5]
			if (core_gie_clear || service) begin
				samp1_q <= 1'b0;
				samp2_q <= 1'b0;
			end else if (phase_q[0]) begin
				samp1_q <= core_irq; // see [RL15]
				samp2_q <= samp1_q & core_irq;
			end
			// Hardware saves only the return address, by asking the core to push it  see [RL16]
			vector_load <= service;
			push_return <= service; // see [RL3]
			if (service)
				vector_addr <= `IFVU_VECTOR;
			if (s_axi_awvalid && s_axi_awready) begin
				awaddr_q <= s_axi_awaddr;
				aw_full_q <= 1'b1;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				// Registers are one byte wide; only lane 0 carries data
				wdata_q <= s_axi_wstrb[0] ? s_axi_wdata[7:0] : `IFVU_RST8;
				w_full_q <= 1'b1;
			end
			if (aw_full_q && w_full_q && !s_axi_bvalid) begin
				s_axi_bresp <= mapped(awaddr_q) ? `IFVU_RESP_OKAY : `IFVU_RESP_SLVERR;
				s_axi_bvalid <= 1'b1;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				aw_full_q <= 1'b0;
				w_full_q <= 1'b0;
				if (s_axi_bresp == `IFVU_RESP_OKAY) begin
					if (hit(awaddr_q, `IFVU_IDX_PEN))
						pen_q <= wdata_q & `IFVU_PERI_MASK;
					if (hit(awaddr_q, `IFVU_IDX_OPTION))
						option_q <= wdata_q;
					if (hit(awaddr_q, `IFVU_IDX_PINEN))
						pinen_q <= wdata_q & `IFVU_PINEN_MASK;
				end
			end
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= mapped(s_axi_araddr) ? `IFVU_RESP_OKAY : `IFVU_RESP_SLVERR;
				s_axi_rdata <= {`IFVU_DW{1'b0}};
				if (hit(s_axi_araddr, `IFVU_IDX_CTRL))
					s_axi_rdata[7:0] <= ctrl_q;
				if (hit(s_axi_araddr, `IFVU_IDX_PFLAG))
					s_axi_rdata[7:0] <= pflag_q;
				if (hit(s_axi_araddr, `IFVU_IDX_PEN))
					s_axi_rdata[7:0] <= pen_q;
				if (hit(s_axi_araddr, `IFVU_IDX_OPTION))
					s_axi_rdata[7:0] <= option_q;
				if (hit(s_axi_araddr, `IFVU_IDX_PINEN))
					s_axi_rdata[7:0] <= pinen_q;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end
endmodule
`default_nettype wire
